// [mmad_pkg.sv]
// package of constants for the memory map address decoder
package mmad_pkg;
  // ********
  // address widths
  // ********
  localparam int ADDR_W      = 24;
  localparam int OFFSET_W    = 16;
  localparam int PAGE_W      = 8;
  localparam int IO_ADDR_W   = 18;
  localparam int IO_IMM_W    = 10;
  localparam int NUM_BANKS   = 4;
  localparam int BOOT_ROM_W  = 10;

  // ********
  // fixed pages
  // ********
  localparam logic [7:0] INT_PAGE      = 8'h00;
  localparam logic [7:0] BOOT_PAGE     = 8'hff;
  localparam logic [7:0] IO_ONCHIP_TOP = 8'h07;
  localparam logic [7:0] BOOT_PAGES    = 8'hfd;

  // ********
  // reset bank boundaries (upper page of banks 0..2)
  // ********
  localparam logic [7:0] BANK0_LAST_RST = 8'h3f;
  localparam logic [7:0] BANK1_LAST_RST = 8'h7f;
  localparam logic [7:0] BANK2_LAST_RST = 8'hbf;
  localparam logic [7:0] BANK3_LAST     = 8'hfe;

  // ********
  // per space control register fields
  // ********
  localparam int CTL_RWAIT_LSB = 0;
  localparam int CTL_WWAIT_LSB = 3;
  localparam int CTL_WAIT_MODE = 6;
  localparam int CTL_CLKDIV_LSB= 8;
  localparam int CTL_WHOLD     = 11;
  localparam int CTL_POLARITY  = 12;
  localparam int CTL_WIDTH16   = 13;
  localparam logic [15:0] CTL_RST = 16'h2000;
  localparam int NUM_SPACES    = 6;

  // ********
  // axi4-lite map (byte addresses)
  // ********
  localparam logic [7:0] A_DATA_PAGE0 = 8'h00;
  localparam logic [7:0] A_DATA_PAGE1 = 8'h04;
  localparam logic [7:0] A_JUMP_PAGE  = 8'h08;
  localparam logic [7:0] A_IO_PAGE    = 8'h0c;
  localparam logic [7:0] A_BOUND      = 8'h10;
  localparam logic [7:0] A_STATUS     = 8'h14;
  localparam logic [7:0] A_CTL_BASE   = 8'h20;
  localparam logic [1:0] RESP_OK      = 2'b00;
  localparam logic [1:0] RESP_SLVERR  = 2'b10;

  // ********
  // request sources
  // ********
  typedef enum logic [2:0] {
    SRC_CORE = 3'b001,
    SRC_DMA  = 3'b010,
    SRC_HOST = 3'b100
  } mmad_src_t;
endpackage : mmad_pkg

// [mmad_space_decode.sv]
// combinational decode of one 24-bit address into its memory space
`timescale 1ns/100ps
module mmad_space_decode (
  input  wire logic [23:0] addr,
  input  wire logic        io_space,
  input  wire logic        boot_space,
  input  wire logic [7:0]  bank0_last,
  input  wire logic [7:0]  bank1_last,
  input  wire logic [7:0]  bank2_last,
  output logic             internal_hit,
  output logic [3:0]       bank_hit,
  output logic             io_ext_hit,
  output logic             boot_hit
);
  logic [7:0] page;
  logic       rom_hit;

  // ********
  // page compare against boundaries
  // ********
  always_comb begin
    page         = addr[23:16];
    rom_hit      = (page == mmad_pkg::BOOT_PAGE) && (addr[15:10] == 6'h00);
    internal_hit = 1'b0;
    bank_hit     = 4'h0;
    io_ext_hit   = 1'b0;
    boot_hit     = 1'b0;
    if (io_space) begin
      // io pages 0..7 on-chip, rest to io select
      if (addr[17:10] > mmad_pkg::IO_ONCHIP_TOP) begin // [R10] [R17]
        io_ext_hit = 1'b1;
      end else begin
        internal_hit = 1'b1;
      end
    end else if (boot_space) begin
      // boot space pages 1..253 off chip
      if (page != mmad_pkg::INT_PAGE && page <= mmad_pkg::BOOT_PAGES) begin // [R13]
        boot_hit = 1'b1;
      end else begin
        internal_hit = 1'b1;
      end
    end else if (page == mmad_pkg::INT_PAGE || rom_hit) begin // [R16] [R18] [R5]
      internal_hit = 1'b1;
    end else if (page <= bank0_last) begin // [R9]
      bank_hit = 4'h1;
    end else if (page <= bank1_last) begin
      bank_hit = 4'h2;
    end else if (page <= bank2_last) begin
      bank_hit = 4'h4;
    end else if (page <= mmad_pkg::BANK3_LAST) begin
      bank_hit = 4'h8;
    end else begin
      bank_hit = 4'h8; // upper page 255 above rom
    end
  end
endmodule : mmad_space_decode

// [mmad_addr_gen.sv]
// address generation for data, program and io accesses
`timescale 1ns/100ps
module mmad_addr_gen (
  input  wire logic [15:0] dag0_index,
  input  wire logic [15:0] dag1_index,
  input  wire logic [7:0]  data_page0,
  input  wire logic [7:0]  data_page1,
  input  wire logic [23:0] program_counter,
  input  wire logic [15:0] rel_offset,
  input  wire logic [23:0] direct_addr,
  input  wire logic [15:0] indirect_reg,
  input  wire logic [7:0]  jump_page_reg,
  input  wire logic [1:0]  branch_kind,
  input  wire logic [7:0]  io_page_reg,
  input  wire logic [9:0]  io_imm,
  output logic [23:0]      dag0_addr,
  output logic [23:0]      dag1_addr,
  output logic [23:0]      branch_addr,
  output logic [17:0]      io_addr
);
  // ********
  // page plus offset concatenation
  // ********
  function automatic logic [23:0] paged(input logic [7:0] pg, input logic [15:0] off);
    paged = {pg, off};
  endfunction : paged

  always_comb begin
    dag0_addr = paged(data_page0, dag0_index); // [R2]
    dag1_addr = paged(data_page1, dag1_index); // [R2]
    io_addr   = {io_page_reg, io_imm}; // [R11]
    unique case (branch_kind)
      2'd0:    branch_addr = program_counter + {{8{rel_offset[15]}}, rel_offset}; // [R3]
      2'd1:    branch_addr = direct_addr; // [R3]
      2'd2:    branch_addr = paged(jump_page_reg, indirect_reg); // [R4]
      default: branch_addr = program_counter;
    endcase
  end
endmodule : mmad_addr_gen

// [mmad_top.sv]
// top of the memory map address decoder with axi4-lite registers
// Summary of operation
// [R1] one 16M-word space reached over separate 24-bit program and data buses
// [R2] data address is data page register over the 16-bit index
// [R3] relative branches add to program counter; direct branches use 24-bit immediate
// [R4] indirect branches take upper eight bits from the jump page register
// [R5] 1K boot rom on page 255; boot modes start at that rom
// [R6] each off-chip space has its own access control register
// [R7] external port width selectable 8 or 16 bits for all spaces
// [R8] bank boundaries reset to 1-63, 64-127, 128-191, 192-254, then writable
// [R9] upper eight address bits compared to boundaries select one bank
// [R10] io space 256K; lowest 8K on-chip, rest off-chip with io select
// [R11] io address is io page register over 10-bit immediate
// [R12] io space reachable by core and by host port
// [R13] boot space is one 253-page off-chip bank with own select
// [R14] host internal access takes one cycle; external host access never stalls core
// [R15] dma takes single cycles, never owns the bus
// [R16] four 16K internal blocks fill page 0, never off-chip
// [R17] io pages are 1K; pages 0-7 on-chip
// [R18] at most one select active; none for page 0 or boot rom
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
module mmad_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // core data address generators
  input  wire logic [15:0] dag0_index,
  input  wire logic [15:0] dag1_index,
  input  wire logic        dag_sel,
  input  wire logic        core_data_req,
  // sequencer
  input  wire logic [23:0] program_counter,
  input  wire logic [15:0] rel_offset,
  input  wire logic [23:0] direct_addr,
  input  wire logic [15:0] indirect_reg,
  input  wire logic [1:0]  branch_kind,
  input  wire logic        core_fetch_req,
  // core io and boot accesses
  input  wire logic [9:0]  io_imm,
  input  wire logic        core_io_req,
  input  wire logic        boot_access,
  input  wire logic        boot_mode_rom,
  // dma and host
  input  wire logic        dma_req,
  input  wire logic [23:0] dma_addr,
  input  wire logic        dma_boot,
  input  wire logic        host_req,
  input  wire logic [23:0] host_addr,
  input  wire logic        host_io,
  input  wire logic        host_boot,
  // results
  output logic [23:0]      program_addr_bus,
  output logic [23:0]      data_addr_bus,
  output logic [23:0]      ext_addr,
  output logic             ext_internal,
  output logic [3:0]       bank_select_n,
  output logic             io_space_select,
  output logic             boot_space_select,
  output logic             ext_width16,
  output logic [15:0]      ext_ctl,
  output logic [23:0]      reset_vector,
  output logic             core_stall,
  output logic             dma_grant,
  output logic             host_grant
);
  // ********
  // register state
  // ********
  logic [7:0]  data_page0, next_data_page0;
  logic [7:0]  data_page1, next_data_page1;
  logic [7:0]  jump_page_reg, next_jump_page_reg;
  logic [7:0]  io_page_reg, next_io_page_reg;
  logic [7:0]  bank0_last, next_bank0_last;
  logic [7:0]  bank1_last, next_bank1_last;
  logic [7:0]  bank2_last, next_bank2_last;
  logic [15:0] space_ctl [mmad_pkg::NUM_SPACES];
  logic [15:0] next_space_ctl [mmad_pkg::NUM_SPACES];
  logic        aw_held, next_aw_held;
  logic [7:0]  aw_addr, next_aw_addr;
  logic        w_held, next_w_held;
  logic [31:0] w_data, next_w_data;
  logic        bvalid, next_bvalid;
  logic [1:0]  bresp, next_bresp;
  logic        rvalid, next_rvalid;
  logic [1:0]  rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  // access state
  logic [23:0] pa_q, next_pa_q;
  logic [23:0] da_q, next_da_q;
  logic [23:0] ea_q, next_ea_q;
  logic        int_q, next_int_q;
  logic [3:0]  bank_q, next_bank_q;
  logic        io_q, next_io_q;
  logic        boot_q, next_boot_q;
  logic [15:0] ctl_q, next_ctl_q;
  logic        stall_q, next_stall_q;
  logic        dgnt_q, next_dgnt_q;
  logic        hgnt_q, next_hgnt_q;
  logic [23:0] rv_q, next_rv_q;
  logic [23:0] dag0_addr, dag1_addr, branch_addr;
  logic [17:0] io_addr;
  logic [23:0] sel_addr;
  logic        sel_io, sel_boot;
  logic        d_int;
  logic [3:0]  d_bank;
  logic        d_io, d_boot;
  logic [2:0]  space_idx;
  logic        do_write;
  logic [7:0]  wr_addr;
  logic [31:0] status_word;
  // ********
  // address generators
  // ********
  mmad_addr_gen u_gen (
    .dag0_index      (dag0_index),
    .dag1_index      (dag1_index),
    .data_page0      (data_page0),
    .data_page1      (data_page1),
    .program_counter (program_counter),
    .rel_offset      (rel_offset),
    .direct_addr     (direct_addr),
    .indirect_reg    (indirect_reg),
    .jump_page_reg   (jump_page_reg),
    .branch_kind     (branch_kind),
    .io_page_reg     (io_page_reg),
    .io_imm          (io_imm),
    .dag0_addr       (dag0_addr),
    .dag1_addr       (dag1_addr),
    .branch_addr     (branch_addr),
    .io_addr         (io_addr)
  );
  // ********
  // source priority: core, then stolen cycles
  // ********
  always_comb begin
    sel_addr = 24'h000000;
    sel_io   = 1'b0;
    sel_boot = 1'b0;
    if (core_io_req) begin
      sel_addr = {6'h00, io_addr}; // [R12]
      sel_io   = 1'b1;
    end else if (core_data_req) begin
      sel_addr = dag_sel ? dag1_addr : dag0_addr;
      sel_boot = boot_access;
    end else if (dma_req) begin
      sel_addr = dma_addr; // [R15]
      sel_boot = dma_boot; // [R13]
    end else if (host_req) begin
      sel_addr = host_addr; // [R12] [R14]
      sel_io   = host_io;
      sel_boot = host_boot;
    end
  end

  mmad_space_decode u_dec (
    .addr         (sel_addr),
    .io_space     (sel_io),
    .boot_space   (sel_boot),
    .bank0_last   (bank0_last),
    .bank1_last   (bank1_last),
    .bank2_last   (bank2_last),
    .internal_hit (d_int),
    .bank_hit     (d_bank),
    .io_ext_hit   (d_io),
    .boot_hit     (d_boot)
  );

  // ********
  // access outputs next values
  // ********
  always_comb begin
    space_idx    = 3'd0;
    for (int i = 0; i < mmad_pkg::NUM_BANKS; i++) begin
      if (d_bank[i]) space_idx = 3'(i);
    end
    if (d_io) space_idx = 3'd4;
    if (d_boot) space_idx = 3'd5;
    next_pa_q    = core_fetch_req ? branch_addr : pa_q; // [R1]
    next_da_q    = core_data_req ? (dag_sel ? dag1_addr : dag0_addr) : da_q; // [R1]
    next_ea_q    = sel_addr;
    next_int_q   = d_int;
    next_bank_q  = d_bank; // [R18]
    next_io_q    = d_io;
    next_boot_q  = d_boot;
    next_ctl_q   = space_ctl[space_idx]; // [R6]
    // host steals one cycle for an internal access to page 0
    next_stall_q = host_req && !host_io && !host_boot && d_int && !core_io_req
                   && (host_addr[23:16] == mmad_pkg::INT_PAGE) && !core_data_req && !dma_req; // [R14]
    next_dgnt_q  = dma_req && !core_io_req && !core_data_req; // [R15]
    next_hgnt_q  = host_req && !core_io_req && !core_data_req && !dma_req;
    next_rv_q    = boot_mode_rom ? {mmad_pkg::BOOT_PAGE, 16'h0000} : 24'h000000; // [R5]
  end

  // ********
  // axi write and read next values
  // ********
  always_comb begin
    {next_aw_held, next_aw_addr, next_w_held, next_w_data, next_bvalid, next_bresp} =
      {aw_held, aw_addr, w_held, w_data, bvalid, bresp};
    {next_rvalid, next_rresp, next_rdata} = {rvalid, rresp, rdata};
    {next_data_page0, next_data_page1, next_jump_page_reg, next_io_page_reg} =
      {data_page0, data_page1, jump_page_reg, io_page_reg};
    {next_bank0_last, next_bank1_last, next_bank2_last} = {bank0_last, bank1_last, bank2_last};
    for (int i = 0; i < mmad_pkg::NUM_SPACES; i++) next_space_ctl[i] = space_ctl[i];
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
    end
    do_write = aw_held && w_held && !bvalid;
    wr_addr  = aw_addr;
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = mmad_pkg::RESP_OK;
      if (s_axi_wstrb[0]) begin
        unique case (wr_addr)
          mmad_pkg::A_DATA_PAGE0: next_data_page0 = w_data[7:0];
          mmad_pkg::A_DATA_PAGE1: next_data_page1 = w_data[7:0];
          mmad_pkg::A_JUMP_PAGE:  next_jump_page_reg = w_data[7:0];
          mmad_pkg::A_IO_PAGE:    next_io_page_reg = w_data[7:0];
          mmad_pkg::A_BOUND: begin
            next_bank0_last = w_data[7:0]; // [R8]
            next_bank1_last = w_data[15:8];
            next_bank2_last = w_data[23:16];
          end
          default: ;
        endcase
      end
      if (wr_addr >= mmad_pkg::A_CTL_BASE && wr_addr < mmad_pkg::A_CTL_BASE + 8'h18) begin
        next_space_ctl[3'((wr_addr - mmad_pkg::A_CTL_BASE) >> 2)] = w_data[15:0]; // [R6] [R7]
      end else if (wr_addr > mmad_pkg::A_STATUS || wr_addr[1:0] != 2'b00) begin
        next_bresp = mmad_pkg::RESP_SLVERR;
      end
    end
    if (bvalid && s_axi_bready) next_bvalid = 1'b0;
    status_word = {20'h00000, boot_q, io_q, int_q, stall_q, bank_q, 4'h0};
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = mmad_pkg::RESP_OK;
      next_rdata  = 32'h00000000;
      unique case (s_axi_araddr)
        mmad_pkg::A_DATA_PAGE0: next_rdata = {24'h000000, data_page0};
        mmad_pkg::A_DATA_PAGE1: next_rdata = {24'h000000, data_page1};
        mmad_pkg::A_JUMP_PAGE:  next_rdata = {24'h000000, jump_page_reg};
        mmad_pkg::A_IO_PAGE:    next_rdata = {24'h000000, io_page_reg};
        mmad_pkg::A_BOUND:      next_rdata = {8'h00, bank2_last, bank1_last, bank0_last};
        mmad_pkg::A_STATUS:     next_rdata = status_word;
        default: begin
          if (s_axi_araddr >= mmad_pkg::A_CTL_BASE && s_axi_araddr < mmad_pkg::A_CTL_BASE + 8'h18
              && s_axi_araddr[1:0] == 2'b00) begin
            next_rdata = {16'h0000, space_ctl[3'((s_axi_araddr - mmad_pkg::A_CTL_BASE) >> 2)]};
          end else begin
            next_rresp = mmad_pkg::RESP_SLVERR;
          end
        end
      endcase
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // ********
  // registers
  // ********
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {data_page0, data_page1, jump_page_reg, io_page_reg} <= '0;
      bank0_last <= mmad_pkg::BANK0_LAST_RST; // [R8]
      bank1_last <= mmad_pkg::BANK1_LAST_RST;
      bank2_last <= mmad_pkg::BANK2_LAST_RST;
      for (int i = 0; i < mmad_pkg::NUM_SPACES; i++) space_ctl[i] <= mmad_pkg::CTL_RST;
      {aw_held, aw_addr, w_held, w_data, bvalid, bresp, rvalid, rresp, rdata} <= '0;
      {pa_q, da_q, ea_q, bank_q, io_q, boot_q, stall_q, dgnt_q, hgnt_q, rv_q} <= '0;
      int_q <= 1'b1;
      ctl_q <= mmad_pkg::CTL_RST;
    end else begin
      {data_page0, data_page1, jump_page_reg, io_page_reg} <=
        {next_data_page0, next_data_page1, next_jump_page_reg, next_io_page_reg};
      {bank0_last, bank1_last, bank2_last} <= {next_bank0_last, next_bank1_last, next_bank2_last};
      for (int i = 0; i < mmad_pkg::NUM_SPACES; i++) space_ctl[i] <= next_space_ctl[i];
      {aw_held, aw_addr, w_held, w_data, bvalid, bresp} <=
        {next_aw_held, next_aw_addr, next_w_held, next_w_data, next_bvalid, next_bresp};
      {rvalid, rresp, rdata} <= {next_rvalid, next_rresp, next_rdata};
      {pa_q, da_q, ea_q, int_q, bank_q, io_q} <=
        {next_pa_q, next_da_q, next_ea_q, next_int_q, next_bank_q, next_io_q};
      {boot_q, ctl_q, stall_q, rv_q} <= {next_boot_q, next_ctl_q, next_stall_q, next_rv_q};
      {dgnt_q, hgnt_q} <= {next_dgnt_q, next_hgnt_q};
    end
  end

  // ********
  // output drive
  // ********
  assign s_axi_awready     = !aw_held;
  assign s_axi_wready      = !w_held;
  assign s_axi_bvalid      = bvalid;
  assign s_axi_bresp       = bresp;
  assign s_axi_arready     = !rvalid;
  assign s_axi_rvalid      = rvalid;
  assign s_axi_rresp       = rresp;
  assign s_axi_rdata       = rdata;
  assign program_addr_bus  = pa_q;
  assign data_addr_bus     = da_q;
  assign ext_addr          = ea_q;
  assign ext_internal      = int_q;
  assign bank_select_n     = ~bank_q; // [R9]
  assign io_space_select   = io_q; // [R10]
  assign boot_space_select = boot_q; // [R13]
  assign ext_ctl           = ctl_q;
  assign ext_width16       = ctl_q[mmad_pkg::CTL_WIDTH16]; // [R7]
  assign core_stall        = stall_q;
  assign dma_grant         = dgnt_q;
  assign host_grant        = hgnt_q;
  assign reset_vector      = rv_q;
endmodule : mmad_top

// [mmad_top_asserts.sv]
// assertion checker for the address decoder ports
`timescale 1ns/100ps
module mmad_top_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [3:0]  bank_select_n,
  input wire logic        io_space_select,
  input wire logic        boot_space_select,
  input wire logic        ext_internal,
  input wire logic        dma_req,
  input wire logic [23:0] dma_addr,
  input wire logic        core_io_req,
  input wire logic        core_data_req,
  input wire logic        core_fetch_req,
  input wire logic [1:0]  branch_kind,
  input wire logic [23:0] direct_addr,
  input wire logic [15:0] indirect_reg,
  input wire logic [23:0] program_addr_bus,
  input wire logic        boot_mode_rom,
  input wire logic [23:0] reset_vector,
  input wire logic        core_stall,
  input wire logic        host_req
);
  // ********
  // properties
  // ********
  wire logic dma_only;
  // dma wins only when the core has no io or data request
  assign dma_only = dma_req & ~core_io_req & ~core_data_req;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_one_select: assert property (
    $countones({~bank_select_n, io_space_select, boot_space_select}) <= 1) else $error("several selects");
  a_int_quiet: assert property (
    ext_internal |-> bank_select_n == 4'hf && !io_space_select && !boot_space_select) else $error("select on chip");
  a_page0_int: assert property (
    dma_only && dma_addr[23:16] == 8'h00 |=> ext_internal) else $error("page zero off chip");
  a_rom_int: assert property (
    dma_only && dma_addr[23:10] == 14'h3fc0 |=> ext_internal) else $error("boot rom off chip");
  a_direct_br: assert property (
    core_fetch_req && branch_kind == 2'h1 |=> program_addr_bus == $past(direct_addr)) else $error("direct target");
  a_indirect_br: assert property (
    core_fetch_req && branch_kind == 2'h2 |=> program_addr_bus[15:0] == $past(indirect_reg)) else $error("indirect");
  a_boot_vec: assert property (
    boot_mode_rom |=> reset_vector == 24'hff0000) else $error("reset vector");
  a_stall_src: assert property (
    core_stall |-> $past(host_req)) else $error("stall without host");
endmodule : mmad_top_asserts

bind mmad_top mmad_top_asserts u_asserts (.*);

// [mmad_ext_model.sv]
// far side model: external memories and peripherals behind the selects
`timescale 1ns/100ps
module mmad_ext_model (
  input wire logic        aclk,
  input wire logic [23:0] ext_addr,
  input wire logic [3:0]  bank_select_n,
  input wire logic        io_space_select,
  input wire logic        boot_space_select,
  output logic [15:0]     rd_data = 16'h5a5a
);
  // ********
  // answer with an address pattern, toggle when released
  // ********
  always @(posedge aclk) begin
    if (~&bank_select_n | io_space_select | boot_space_select) rd_data <= ~ext_addr[15:0];
    else rd_data <= ~rd_data;
  end
endmodule : mmad_ext_model

// [mmad_top_tb.sv]
// self-checking testbench of the address decoder
`timescale 1ns/100ps
module mmad_top_tb;
  // ********
  // signals
  // ********
  logic aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0, dag_sel = '0, core_data_req = '0, core_fetch_req = '0;
  logic core_io_req = '0, boot_access = '0, boot_mode_rom = '0, dma_req = '0, dma_boot = '0;
  logic host_req = '0, host_io = '0, host_boot = '0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, ext_internal, io_space_select, boot_space_select;
  logic ext_width16, core_stall, dma_grant, host_grant;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0, b0, b1, b2, pg;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd, r, seed = 32'h00017d8c;
  logic [3:0]  s_axi_wstrb = 4'hf, bank_select_n;
  logic [15:0] dag0_index = '0, dag1_index = '0, rel_offset = '0, indirect_reg = '0, ext_ctl;
  logic [23:0] program_counter = '0, direct_addr = '0, dma_addr = '0, host_addr = '0, a, e;
  logic [23:0] program_addr_bus, data_addr_bus, ext_addr, reset_vector;
  logic [9:0]  io_imm = '0;
  logic [1:0]  branch_kind = '0, s_axi_bresp, s_axi_rresp, rs;
  logic [23:0] corner [7] = '{24'h000000, 24'h3fffff, 24'h400000, 24'hff03ff, 24'hff0400, 24'hfe0000, 24'h010000};
  logic [23:0] host_tab [3] = '{24'h001000, 24'h500000, 24'h008000};
  int errors = 0, comparisons = 0;

  mmad_top u_dut (.*);
  mmad_ext_model u_mem (.aclk, .ext_addr, .bank_select_n, .io_space_select, .boot_space_select, .rd_data());

  // clock
  always #50 aclk = ~aclk;

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // expected bank selects
  function logic [3:0] exp_sel(input logic [23:0] x);
    if (x[23:16] == 8'h00 || (x[23:16] == 8'hff && x[15:10] == 6'h00)) return 4'hf;
    if (x[23:16] <= b0) return 4'he;
    if (x[23:16] <= b1) return 4'hd;
    if (x[23:16] <= b2) return 4'hb;
    return 4'h7;
  endfunction : exp_sel

  task check(input string n, input logic [31:0] ex, input logic [31:0] g);
    comparisons++;
    if (g !== ex) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, ex, g);
    end
  endtask : check

  task report_and_stop;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop

  task wr_reg(input logic [7:0] ad, input logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {ad, d, 3'h7};
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
    do @(posedge aclk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask : wr_reg

  task rd_reg(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {ad, 2'h3};
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (!s_axi_rvalid);
    {d, resp} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 0;
  endtask : rd_reg

  // one request edge, then sample outputs
  task fire;
    @(posedge aclk);
    {dma_req, dma_boot, core_io_req, core_data_req, core_fetch_req, host_req, host_io, boot_mode_rom} <= '0;
    @(negedge aclk);
  endtask : fire

  // ********
  // main sequence
  // ********
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    {b0, b1, b2} = 24'h3f7fbf;
    @(negedge aclk);
    check("sel_rst", 4'hf, bank_select_n);
    rd_reg(8'h10, rd, rs);
    check("bound_rst", 32'h00bf7f3f, rd);
    rd_reg(8'h34, rd, rs);
    check("ctl_rst", 32'h00002000, rd);
    rd_reg(8'h40, rd, rs);
    check("unmapped", mmad_pkg::RESP_SLVERR, rs);
    wr_reg(8'h24, '0, rs);
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 40; i++) begin
        a = (i < 7) ? corner[i] : rnd();
        @(posedge aclk);
        {dma_req, dma_addr} <= {1'h1, a};
        fire();
        check("bank_sel", exp_sel(a), bank_select_n);
        check("internal", exp_sel(a) == 4'hf, ext_internal);
        check("width16", exp_sel(a) != 4'hd, ext_width16);
        check("ext_ctl", exp_sel(a) == 4'hd ? 32'h0 : 32'h2000, ext_ctl);
        check("dma_grant", 1, dma_grant);
        check("ext_addr", a, ext_addr);
      end
      wr_reg(8'h10, 32'h00c08020, rs);
      check("wr_resp", mmad_pkg::RESP_OK, rs);
      {b0, b1, b2} = 24'h2080c0;
    end
    for (int i = 0; i < 2; i++) begin
      @(posedge aclk);
      {dma_req, dma_boot, dma_addr} <= {2'h3, 8'hfd + i[7:0], 16'h1234};
      fire();
      check("boot_sel", i == 0, boot_space_select);
      wr_reg(8'h0c, 32'h7 + i, rs);
      r = rnd();
      @(posedge aclk);
      {core_io_req, io_imm, dma_req, dma_addr} <= {1'h1, r[9:0], 1'h1, 24'h400000};
      fire();
      check("io_sel", i, io_space_select);
      check("io_addr", {8'h7 + i[7:0], r[9:0]}, ext_addr[17:0]);
      check("io_banks", 4'hf, bank_select_n);
      check("io_grant", 0, dma_grant);
      r = rnd();
      pg = r[7:0];
      wr_reg(i ? 8'h04 : 8'h00, {24'h0, pg}, rs);
      r = rnd();
      @(posedge aclk);
      {core_data_req, dag_sel, dag0_index, dag1_index} <= {1'h1, i[0], r};
      fire();
      check("data_addr", {pg, i ? r[15:0] : r[31:16]}, data_addr_bus);
    end
    for (int j = 0; j < 3; j++) begin
      @(posedge aclk);
      {host_req, host_io, host_addr} <= {1'h1, j == 2, host_tab[j]};
      fire();
      check("stall", j == 0, core_stall);
      check("host_io", j == 2, io_space_select);
      check("host_grant", 1, host_grant);
    end
    r = rnd();
    pg = r[7:0];
    wr_reg(8'h08, {24'h0, pg}, rs);
    for (int k = 0; k < 4; k++) begin
      r = rnd();
      case (k)
        0: e = r[23:0] + {{8{r[31]}}, r[31:16]};
        1: e = ~r[23:0];
        2: e = {pg, r[15:0]};
        default: e = r[23:0];
      endcase
      @(posedge aclk);
      {program_counter, rel_offset, direct_addr, indirect_reg} <= {r[23:0], r[31:16], ~r[23:0], r[15:0]};
      {branch_kind, core_fetch_req, boot_mode_rom} <= {k[1:0], 1'h1, k == 3};
      fire();
      check("branch", e, program_addr_bus);
    end
    check("rst_vec", 24'hff0000, reset_vector);
    report_and_stop();
  end

  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge aclk);
    errors++;
    report_and_stop();
  end
endmodule : mmad_top_tb
